// [monitor_pkg.sv]
// constants for the hour meters, display scaling and analog monitor output
package monitor_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_DISPLAY_SEL = 8'h00;
  localparam logic [7:0] ADDR_RUN_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENERGY_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_DIGIT_SEL = 8'h0C;
  localparam logic [7:0] ADDR_FREQ_REF = 8'h10;
  localparam logic [7:0] ADDR_CURR_REF = 8'h14;
  localparam logic [7:0] ADDR_AO_FUNC = 8'h18;
  localparam logic [7:0] ADDR_AO_GAIN = 8'h1C;
  localparam logic [7:0] ADDR_WRITE_PROT = 8'h20;
  localparam logic [7:0] ADDR_POWERED_HOURS = 8'h24;
  localparam logic [7:0] ADDR_RUN_HOURS = 8'h28;
  localparam logic [7:0] ADDR_POWERED_WRAPS = 8'h2C;
  localparam logic [7:0] ADDR_RUN_WRAPS = 8'h30;
  localparam logic [7:0] ADDR_DISPLAY_VALUE = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;

  // status register bit positions
  localparam int STAT_RUNNING = 0;
  localparam int STAT_DEC_LO = 1;
  localparam int STAT_DEC_HI = 2;

  // setting codes
  localparam logic [15:0] SEL_POWERED_HOURS = 16'h0014;
  localparam logic [15:0] SEL_RUN_HOURS = 16'h0017;
  localparam logic [15:0] SEL_ENERGY = 16'h0019;
  localparam logic [15:0] VAL_NO_FUNCTION = 16'h270F;
  localparam logic [15:0] VAL_ENERGY_ALT = 16'h000A;
  localparam logic [15:0] VAL_ZERO = 16'h0000;
  localparam logic [15:0] DIGIT_INTEGER = 16'h0000;
  localparam logic [15:0] DIGIT_ONE_DEC = 16'h0001;
  localparam logic [15:0] AO_FUNC_FREQ = 16'h0001;
  localparam logic [15:0] AO_FUNC_CURR = 16'h0002;
  localparam logic [15:0] AO_FUNC_REF = 16'h0015;
  localparam logic [15:0] PROTECT_ON = 16'h0001;

  // reset values and write limits
  localparam logic [15:0] RST_DISPLAY_SEL = 16'h0000;
  localparam logic [15:0] RST_FREQ_REF = 16'h1388;
  localparam logic [15:0] RST_AO_FUNC = 16'h0001;
  localparam logic [15:0] RST_AO_GAIN = 16'h1000;
  localparam logic [15:0] RST_WRITE_PROT = 16'h0000;
  localparam logic [15:0] FREQ_REF_MAX = 16'h9C40;
  localparam logic [15:0] CURR_REF_MAX = 16'hC350;
  localparam logic [15:0] METER_MAX = 16'hFFFF;

  // gain is unsigned with this many fraction bits
  localparam int GAIN_FRAC = 12;

  // decimal thresholds for display rounding
  localparam logic [15:0] BELOW_099_TENTHS = 16'h000A;
  localparam logic [15:0] BELOW_099_HUNDREDTHS = 16'h0063;

  // timing
  localparam longint unsigned CLK_HZ = 64'd20000000;
  localparam longint unsigned HOUR_S = 64'd3600;
  localparam longint unsigned HOUR_CYCLES = HOUR_S * CLK_HZ;

endpackage : monitor_pkg

// [hour_meter_monitor.sv]
// hour meters, monitor display scaling and analog monitor output scaling
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module hour_meter_monitor #(
  parameter logic [36:0] HOUR_CYCLES = 37'(monitor_pkg::HOUR_CYCLES),
  parameter int AO_W = 12,
  parameter logic [15:0] RATED_CURRENT = 16'h03E8
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset, // async reset, active high, power-on
  input wire logic [7:0] addr, // register byte address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd
  input wire logic motor_running, // drive running, asynchronous
  input wire logic [15:0] monitor_value, // selected monitor raw value
  input wire logic [1:0] monitor_decimals, // decimals in monitor_value
  input wire logic [15:0] freq_monitor, // frequency, 0.01 Hz units
  input wire logic [15:0] current_monitor, // current, 0.01 A units
  input wire logic nv_restore, // load stored meter values
  input wire logic [15:0] nv_powered_hours, // stored powered hours
  input wire logic [15:0] nv_run_hours, // stored run hours
  input wire logic [15:0] nv_powered_wraps, // stored powered wraps
  input wire logic [15:0] nv_run_wraps, // stored run wraps
  output logic [15:0] powered_hours, // powered hour meter
  output logic [15:0] run_hours, // run hour meter
  output logic [15:0] powered_time_wrap_count, // powered meter wraps
  output logic [15:0] run_time_wrap_count, // run meter wraps
  output logic nv_update, // pulse: meter values changed
  output logic energy_clear, // pulse: clear energy monitor
  output logic [15:0] display_value, // formatted display value
  output logic [1:0] display_decimals, // decimals of display_value
  output logic [AO_W-1:0] analog_monitor_output // analog output code
);

  localparam logic [AO_W-1:0] AO_FULL = {AO_W{1'b1}};

  logic run_meta_q;
  logic run_sync_q;
  logic [15:0] monitor_display_select_q;
  logic [15:0] energy_meter_clear_setting_q;
  logic [15:0] decimal_digit_select_q;
  logic [15:0] frequency_full_scale_ref_q;
  logic [15:0] current_full_scale_ref_q;
  logic [15:0] analog_output_function_select_q;
  logic [15:0] analog_output_gain_cal_q;
  logic [15:0] write_protect_select_q;
  logic [36:0] powered_pre_q;
  logic [36:0] run_pre_q;
  logic [15:0] powered_hours_q;
  logic [15:0] run_hours_q;
  logic [15:0] powered_wraps_q;
  logic [15:0] run_wraps_q;
  logic powered_tick;
  logic run_tick;
  logic run_clear;
  logic protect;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic nv_update_q;
  logic energy_clear_q;
  logic [15:0] disp_q;
  logic [15:0] disp_d;
  logic [1:0] disp_dec_q;
  logic [1:0] disp_dec_d;
  logic [AO_W-1:0] ao_q;
  logic [AO_W-1:0] ao_d;

  // running level from outside the clock domain
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_meta_q <= 1'b0;
      run_sync_q <= 1'b0;
    end
    else
    begin
      run_meta_q <= motor_running;
      run_sync_q <= run_meta_q;
    end
  end

  assign protect = (write_protect_select_q == monitor_pkg::PROTECT_ON);
  assign run_clear = wr && (addr == monitor_pkg::ADDR_RUN_CLEAR) && !protect
    && (wdata == monitor_pkg::VAL_ZERO);
  assign powered_tick = (powered_pre_q == HOUR_CYCLES - 37'd1);
  assign run_tick = run_sync_q && (run_pre_q == HOUR_CYCLES - 37'd1);

  // settings that obey write protect, and the write protect select, which is always writable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      monitor_display_select_q <= monitor_pkg::RST_DISPLAY_SEL;
      decimal_digit_select_q <= monitor_pkg::VAL_NO_FUNCTION;
      energy_meter_clear_setting_q <= monitor_pkg::VAL_NO_FUNCTION;
      write_protect_select_q <= monitor_pkg::RST_WRITE_PROT;
      energy_clear_q <= 1'b0;
    end
    else
    begin
      energy_clear_q <= 1'b0;
      if (wr && addr == monitor_pkg::ADDR_WRITE_PROT)
      begin
        write_protect_select_q <= wdata;
      end
      else if (wr && !protect && addr == monitor_pkg::ADDR_DISPLAY_SEL)
      begin
        monitor_display_select_q <= wdata;
      end
      else if (wr && !protect && addr == monitor_pkg::ADDR_DIGIT_SEL)
      begin
        if (wdata == monitor_pkg::DIGIT_INTEGER || wdata == monitor_pkg::DIGIT_ONE_DEC
            || wdata == monitor_pkg::VAL_NO_FUNCTION)
        begin
          decimal_digit_select_q <= wdata;
        end
      end
      else if (wr && !protect && addr == monitor_pkg::ADDR_ENERGY_CLEAR)
      begin
        if (wdata == monitor_pkg::VAL_ZERO)
        begin
          energy_clear_q <= 1'b1;
        end
        else if (wdata == monitor_pkg::VAL_ENERGY_ALT
                 || wdata == monitor_pkg::VAL_NO_FUNCTION)
        begin
          energy_meter_clear_setting_q <= wdata;
        end
      end
    end
  end

  // references and gain are writable at any time; the analog output function select obeys write protect
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      frequency_full_scale_ref_q <= monitor_pkg::RST_FREQ_REF;
      current_full_scale_ref_q <= RATED_CURRENT;
      analog_output_function_select_q <= monitor_pkg::RST_AO_FUNC;
      analog_output_gain_cal_q <= monitor_pkg::RST_AO_GAIN;
    end
    else if (wr)
    begin
      if (addr == monitor_pkg::ADDR_FREQ_REF && wdata <= monitor_pkg::FREQ_REF_MAX)
      begin
        frequency_full_scale_ref_q <= wdata;
      end
      else if (addr == monitor_pkg::ADDR_CURR_REF && wdata <= monitor_pkg::CURR_REF_MAX)
      begin
        current_full_scale_ref_q <= wdata;
      end
      else if (addr == monitor_pkg::ADDR_AO_GAIN)
      begin
        analog_output_gain_cal_q <= wdata;
      end
      else if (addr == monitor_pkg::ADDR_AO_FUNC && !protect)
      begin
        analog_output_function_select_q <= wdata;
      end
    end
  end

  // sub-hour prescalers start at zero on every power-on
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      powered_pre_q <= 37'd0;
    end
    else if (powered_tick)
    begin
      powered_pre_q <= 37'd0;
    end
    else
    begin
      powered_pre_q <= powered_pre_q + 37'd1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_pre_q <= 37'd0;
    end
    else if (run_tick || run_clear)
    begin
      run_pre_q <= 37'd0;
    end
    else if (run_sync_q)
    begin
      run_pre_q <= run_pre_q + 37'd1;
    end
  end

  // powered meter, no software clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      powered_hours_q <= 16'h0000;
      powered_wraps_q <= 16'h0000;
    end
    else if (nv_restore)
    begin
      powered_hours_q <= nv_powered_hours;
      powered_wraps_q <= nv_powered_wraps;
    end
    else if (powered_tick)
    begin
      powered_hours_q <= powered_hours_q + 16'h0001;
      if (powered_hours_q == monitor_pkg::METER_MAX)
      begin
        powered_wraps_q <= powered_wraps_q + 16'h0001;
      end
    end
  end

  // run meter; a clear beats a tick in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_hours_q <= 16'h0000;
      run_wraps_q <= 16'h0000;
    end
    else if (nv_restore)
    begin
      run_hours_q <= nv_run_hours;
      run_wraps_q <= nv_run_wraps;
    end
    else if (run_clear)
    begin
      run_hours_q <= 16'h0000;
    end
    else if (run_tick)
    begin
      run_hours_q <= run_hours_q + 16'h0001;
      if (run_hours_q == monitor_pkg::METER_MAX)
      begin
        run_wraps_q <= run_wraps_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nv_update_q <= 1'b0;
    end
    else
    begin
      nv_update_q <= powered_tick || run_tick || run_clear;
    end
  end

  // display formatting
  always_comb
  begin
    disp_d = monitor_value;
    disp_dec_d = monitor_decimals;
    if (monitor_display_select_q == monitor_pkg::SEL_POWERED_HOURS)
    begin
      disp_d = powered_hours_q;
      disp_dec_d = 2'd0;
    end
    else if (monitor_display_select_q == monitor_pkg::SEL_RUN_HOURS)
    begin
      disp_d = run_hours_q;
      disp_dec_d = 2'd0;
    end
    else if (monitor_display_select_q == monitor_pkg::SEL_ENERGY)
    begin
      disp_d = monitor_value;
      disp_dec_d = monitor_decimals;
    end
    else if (decimal_digit_select_q == monitor_pkg::DIGIT_INTEGER)
    begin
      disp_dec_d = 2'd0;
      if (monitor_decimals == 2'd1)
      begin
        if (monitor_value < monitor_pkg::BELOW_099_TENTHS)
        begin
          disp_d = 16'h0000;
        end
        else
        begin
          disp_d = 16'((17'(monitor_value) + 17'd5) / 17'd10);
        end
      end
      else if (monitor_decimals == 2'd2)
      begin
        if (monitor_value < monitor_pkg::BELOW_099_HUNDREDTHS)
        begin
          disp_d = 16'h0000;
        end
        else
        begin
          disp_d = 16'((17'(monitor_value) + 17'd50) / 17'd100);
        end
      end
      else
      begin
        disp_dec_d = monitor_decimals;
      end
    end
    else if (decimal_digit_select_q == monitor_pkg::DIGIT_ONE_DEC
             && monitor_decimals == 2'd2)
    begin
      disp_d = monitor_value / 16'd10;
      disp_dec_d = 2'd1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      disp_q <= 16'h0000;
      disp_dec_q <= 2'd0;
    end
    else
    begin
      disp_q <= disp_d;
      disp_dec_q <= disp_dec_d;
    end
  end

  // analog output: q scaled to reference, then gain, clamped
  always_comb
  begin
    logic [15:0] qty;
    logic [15:0] ref_v;
    logic [31:0] lin;
    logic [31:0] gained;
    qty = 16'h0000;
    ref_v = 16'h0001;
    lin = 32'd0;
    gained = 32'd0;
    if (analog_output_function_select_q == monitor_pkg::AO_FUNC_FREQ)
    begin
      qty = freq_monitor;
      ref_v = frequency_full_scale_ref_q;
    end
    else if (analog_output_function_select_q == monitor_pkg::AO_FUNC_CURR)
    begin
      qty = current_monitor;
      ref_v = current_full_scale_ref_q;
    end
    if (analog_output_function_select_q == monitor_pkg::AO_FUNC_REF)
    begin
      lin = 32'(AO_FULL);
    end
    else if (ref_v == 16'h0000)
    begin
      lin = (qty == 16'h0000) ? 32'd0 : 32'(AO_FULL);
    end
    else
    begin
      lin = (32'(qty) * 32'(AO_FULL)) / 32'(ref_v);
      if (lin > 32'(AO_FULL))
      begin
        lin = 32'(AO_FULL);
      end
    end
    gained = (lin * 32'(analog_output_gain_cal_q)) >> monitor_pkg::GAIN_FRAC;
    if (gained > 32'(AO_FULL))
    begin
      ao_d = AO_FULL;
    end
    else
    begin
      ao_d = gained[AO_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ao_q <= '0;
    end
    else
    begin
      ao_q <= ao_d;
    end
  end

  // register read
  always_comb
  begin
    rdata_d = 16'h0000;
    if (addr == monitor_pkg::ADDR_DISPLAY_SEL)
    begin
      rdata_d = monitor_display_select_q;
    end
    else if (addr == monitor_pkg::ADDR_RUN_CLEAR)
    begin
      rdata_d = monitor_pkg::VAL_NO_FUNCTION;
    end
    else if (addr == monitor_pkg::ADDR_ENERGY_CLEAR)
    begin
      rdata_d = energy_meter_clear_setting_q;
    end
    else if (addr == monitor_pkg::ADDR_DIGIT_SEL)
    begin
      rdata_d = decimal_digit_select_q;
    end
    else if (addr == monitor_pkg::ADDR_FREQ_REF)
    begin
      rdata_d = frequency_full_scale_ref_q;
    end
    else if (addr == monitor_pkg::ADDR_CURR_REF)
    begin
      rdata_d = current_full_scale_ref_q;
    end
    else if (addr == monitor_pkg::ADDR_AO_FUNC)
    begin
      rdata_d = analog_output_function_select_q;
    end
    else if (addr == monitor_pkg::ADDR_AO_GAIN)
    begin
      rdata_d = analog_output_gain_cal_q;
    end
    else if (addr == monitor_pkg::ADDR_WRITE_PROT)
    begin
      rdata_d = write_protect_select_q;
    end
    else if (addr == monitor_pkg::ADDR_POWERED_HOURS)
    begin
      rdata_d = powered_hours_q;
    end
    else if (addr == monitor_pkg::ADDR_RUN_HOURS)
    begin
      rdata_d = run_hours_q;
    end
    else if (addr == monitor_pkg::ADDR_POWERED_WRAPS)
    begin
      rdata_d = powered_wraps_q;
    end
    else if (addr == monitor_pkg::ADDR_RUN_WRAPS)
    begin
      rdata_d = run_wraps_q;
    end
    else if (addr == monitor_pkg::ADDR_DISPLAY_VALUE)
    begin
      rdata_d = disp_q;
    end
    else if (addr == monitor_pkg::ADDR_STATUS)
    begin
      rdata_d[monitor_pkg::STAT_RUNNING] = run_sync_q;
      rdata_d[monitor_pkg::STAT_DEC_LO] = disp_dec_q[0];
      rdata_d[monitor_pkg::STAT_DEC_HI] = disp_dec_q[1];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q <= 16'h0000;
    end
    else
    begin
      rdata_q <= rd ? rdata_d : 16'h0000;
    end
  end

  assign rdata = rdata_q;
  assign powered_hours = powered_hours_q;
  assign run_hours = run_hours_q;
  assign powered_time_wrap_count = powered_wraps_q;
  assign run_time_wrap_count = run_wraps_q;
  assign nv_update = nv_update_q;
  assign energy_clear = energy_clear_q;
  assign display_value = disp_q;
  assign display_decimals = disp_dec_q;
  assign analog_monitor_output = ao_q;

endmodule // hour_meter_monitor

`default_nettype wire

// [hour_meter_monitor_asserts.sv]
// assertion checker for hour_meter_monitor, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module hour_meter_monitor_asserts #(
  parameter logic [36:0] HOUR_CYCLES = 37'd4
) (
  input wire logic clk, // clock
  input wire logic reset, // async reset
  input wire logic [7:0] addr, // address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [15:0] rdata, // read data
  input wire logic motor_running, // run level
  input wire logic [15:0] monitor_value, // raw value
  input wire logic [1:0] monitor_decimals, // raw decimals
  input wire logic nv_restore, // restore pulse
  input wire logic [15:0] powered_hours, // powered meter
  input wire logic [15:0] run_hours, // run meter
  input wire logic [15:0] powered_time_wrap_count, // powered wraps
  input wire logic [15:0] run_time_wrap_count, // run wraps
  input wire logic energy_clear, // clear pulse
  input wire logic [15:0] display_value, // display
  input wire logic [1:0] display_decimals // display decimals
);
  logic prot_q;
  logic nv_seen_q;
  logic [15:0] sel_q;
  logic [36:0] cyc_q;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // shadows of write protect and display select as the bus leaves them
  always_ff @(posedge clk or posedge reset)
    if (reset)
      prot_q <= 1'b0;
    else if (wr && addr == 8'h20)
      prot_q <= wdata == monitor_pkg::PROTECT_ON;

  always_ff @(posedge clk or posedge reset)
    if (reset)
      sel_q <= 16'h0000;
    else if (wr && addr == 8'h00 && !prot_q)
      sel_q <= wdata;

  // cycles since reset, stops at one hour
  always_ff @(posedge clk or posedge reset)
    if (reset)
      cyc_q <= '0;
    else if (cyc_q < HOUR_CYCLES)
      cyc_q <= cyc_q + 37'd1;

  always_ff @(posedge clk or posedge reset)
    if (reset)
      nv_seen_q <= 1'b0;
    else if (nv_restore)
      nv_seen_q <= 1'b1;

  run_clear_read_a: assert property (rd && addr == 8'h04 |=> rdata == 16'h270F)
    else $error("run clear setting read back wrong");
  partial_hour_a: assert property (cyc_q < HOUR_CYCLES && !nv_seen_q
    |-> powered_hours == 16'h0000 && run_hours == 16'h0000)
    else $error("meter credited a partial hour");
  powered_step_a: assert property (!nv_restore
    |=> 16'(powered_hours - $past(powered_hours)) <= 16'h0001)
    else $error("powered meter moved by more than one");
  powered_wrap_a: assert property ((powered_hours == 16'hFFFF && !nv_restore)
    ##1 powered_hours == 16'h0000
    |-> powered_time_wrap_count == 16'($past(powered_time_wrap_count) + 16'h0001))
    else $error("powered wrap not counted");
  run_wrap_a: assert property ((run_hours == 16'hFFFF && !nv_restore && !wr)
    ##1 run_hours == 16'h0000
    |-> run_time_wrap_count == 16'($past(run_time_wrap_count) + 16'h0001))
    else $error("run wrap not counted");
  run_hold_a: assert property ((!motor_running [*3]) ##0 (!wr && !nv_restore)
    |=> $stable(run_hours))
    else $error("run meter moved while stopped");
  run_clear_a: assert property (wr && addr == 8'h04 && wdata == 16'h0000
    && !prot_q && !nv_restore |=> run_hours == 16'h0000)
    else $error("run meter not cleared");
  energy_clear_a: assert property (wr && addr == 8'h08 && wdata == 16'h0000
    && !prot_q |=> energy_clear)
    else $error("energy clear pulse missing");
  energy_bypass_a: assert property (sel_q == monitor_pkg::SEL_ENERGY
    |=> display_value == $past(monitor_value) && display_decimals == $past(monitor_decimals))
    else $error("energy monitor display altered");

  cover property (wr && addr == 8'h04 && wdata == 16'h0000);
  cover property (powered_hours == 16'hFFFF ##1 powered_hours == 16'h0000);
  cover property (energy_clear);
  cover property (sel_q == monitor_pkg::SEL_ENERGY && monitor_decimals == 2'd2);
endmodule // hour_meter_monitor_asserts

bind hour_meter_monitor hour_meter_monitor_asserts #(.HOUR_CYCLES(HOUR_CYCLES)) chk_inst (
  .clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .motor_running, .monitor_value,
  .monitor_decimals, .nv_restore, .powered_hours, .run_hours, .powered_time_wrap_count,
  .run_time_wrap_count, .energy_clear, .display_value, .display_decimals);
`default_nettype wire

// [hour_meter_monitor_tb.sv]
// self-checking testbench for hour_meter_monitor
`timescale 1ns/1ps
`default_nettype none
module hour_meter_monitor_tb;
  logic clk = 1'b0;
  logic reset;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic motor_running;
  logic [15:0] monitor_value;
  logic [1:0] monitor_decimals;
  logic [15:0] freq_monitor;
  logic [15:0] current_monitor;
  logic nv_restore;
  logic [15:0] nv_powered_hours;
  logic [15:0] nv_run_hours;
  logic [15:0] nv_powered_wraps;
  logic [15:0] nv_run_wraps;
  logic [15:0] powered_hours;
  logic [15:0] run_hours;
  logic [15:0] powered_time_wrap_count;
  logic [15:0] run_time_wrap_count;
  logic nv_update;
  logic energy_clear;
  logic [15:0] display_value;
  logic [1:0] display_decimals;
  logic [11:0] analog_monitor_output;
  int mismatches = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  hour_meter_monitor #(.HOUR_CYCLES(37'd4), .AO_W(12)) dut (
    .clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .motor_running, .monitor_value,
    .monitor_decimals, .freq_monitor, .current_monitor, .nv_restore, .nv_powered_hours,
    .nv_run_hours, .nv_powered_wraps, .nv_run_wraps, .powered_hours, .run_hours,
    .powered_time_wrap_count, .run_time_wrap_count, .nv_update, .energy_clear,
    .display_value, .display_decimals, .analog_monitor_output);

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e, input string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(name, e, rdata);
  endtask

  task automatic power_up();
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic restore(input logic [15:0] p, input logic [15:0] r, input logic [15:0] pw,
    input logic [15:0] rw);
    @(posedge clk);
    nv_restore <= 1'b1;
    nv_powered_hours <= p;
    nv_run_hours <= r;
    nv_powered_wraps <= pw;
    nv_run_wraps <= rw;
    @(posedge clk);
    nv_restore <= 1'b0;
  endtask

  // bounded wait for a meter to leave its maximum
  task automatic wait_wrap(input logic run);
    int i;
    i = 0;
    #1;
    while (i < 40 && (run ? run_hours : powered_hours) === 16'hFFFF)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 40)
    begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic disp(input logic [15:0] v, input logic [1:0] d, input logic [15:0] ev,
    input logic [1:0] ed);
    @(posedge clk);
    monitor_value <= v;
    monitor_decimals <= d;
    repeat (2) @(posedge clk);
    #1 chk("display_value", ev, display_value);
    chk("display_decimals", {14'h0, ed}, {14'h0, display_decimals});
  endtask

  task automatic ao(input logic [15:0] f, input logic [15:0] c, input logic [11:0] e);
    @(posedge clk);
    freq_monitor <= f;
    current_monitor <= c;
    repeat (3) @(posedge clk);
    #1 chk("analog_monitor_output", {4'h0, e}, {4'h0, analog_monitor_output});
  endtask

  task automatic s_hours();
    power_up();
    repeat (3) @(posedge clk);
    #1 chk("powered_hours", 16'h0000, powered_hours);
    repeat (9) @(posedge clk);
    #1 chk("powered_hours", 16'h0003, powered_hours);
    chk("run_hours", 16'h0000, run_hours);
    chk("nv_update", 16'h0001, {15'h0, nv_update});
  endtask

  task automatic s_defaults();
    logic [7:0] a [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
    logic [15:0] e [10] = '{16'h0000, 16'h270F, 16'h270F, 16'h270F, 16'h1388, 16'h03E8,
      16'h0001, 16'h1000, 16'h0000, 16'h0000};
    wr_reg(8'h3C, 16'h1234);
    for (int i = 0; i < 10; i++)
      rd_reg(a[i], e[i], $sformatf("reg_%h", a[i]));
  endtask

  task automatic s_run();
    @(posedge clk);
    motor_running <= 1'b1;
    repeat (23) @(posedge clk);
    motor_running <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("run_hours", 16'h0005, run_hours);
    rd_reg(8'h28, 16'h0005, "run_hours_reg");
    power_up();
    restore(16'h0100, 16'h0005, 16'h0003, 16'h0004);
    motor_running <= 1'b1;
    repeat (2) @(posedge clk);
    motor_running <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("run_hours", 16'h0005, run_hours);
    chk("powered_wraps", 16'h0003, powered_time_wrap_count);
    chk("run_wraps", 16'h0004, run_time_wrap_count);
  endtask

  task automatic s_clear();
    wr_reg(8'h04, 16'h270F);
    #1 chk("run_hours", 16'h0005, run_hours);
    rd_reg(8'h04, 16'h270F, "run_clear_setting");
    wr_reg(8'h04, 16'h0000);
    #1 chk("run_hours", 16'h0000, run_hours);
  endtask

  task automatic s_wrap();
    restore(16'hFFFF, 16'hFFFF, 16'h0007, 16'h0009);
    motor_running <= 1'b1;
    wait_wrap(1'b0);
    chk("powered_hours", 16'h0000, powered_hours);
    chk("powered_wraps", 16'h0008, powered_time_wrap_count);
    wait_wrap(1'b1);
    chk("run_hours", 16'h0000, run_hours);
    chk("run_wraps", 16'h000A, run_time_wrap_count);
    @(posedge clk);
    motor_running <= 1'b0;
  endtask

  task automatic s_energy();
    wr_reg(8'h08, 16'h0000);
    #1 chk("energy_clear", 16'h0001, {15'h0, energy_clear});
    rd_reg(8'h08, 16'h270F, "energy_clear_setting");
    wr_reg(8'h08, 16'h000A);
    wr_reg(8'h08, 16'h0000);
    rd_reg(8'h08, 16'h000A, "energy_clear_setting");
    wr_reg(8'h08, 16'h0005);
    rd_reg(8'h08, 16'h000A, "energy_clear_setting");
  endtask

  task automatic s_display();
    wr_reg(8'h0C, 16'h0000);
    disp(16'h04D2, 2'd1, 16'h007B, 2'd0);
    disp(16'h0009, 2'd1, 16'h0000, 2'd0);
    disp(16'h000A, 2'd1, 16'h0001, 2'd0);
    disp(16'h0062, 2'd2, 16'h0000, 2'd0);
    disp(16'h0063, 2'd2, 16'h0001, 2'd0);
    disp(16'h04E2, 2'd2, 16'h000D, 2'd0);
    wr_reg(8'h0C, 16'h0001);
    disp(16'h04D2, 2'd2, 16'h007B, 2'd1);
    disp(16'h04D2, 2'd1, 16'h04D2, 2'd1);
    disp(16'h004D, 2'd0, 16'h004D, 2'd0);
    wr_reg(8'h0C, 16'h0005);
    rd_reg(8'h0C, 16'h0001, "digit_select");
    wr_reg(8'h0C, 16'h270F);
    disp(16'h04D2, 2'd2, 16'h04D2, 2'd2);
    wr_reg(8'h0C, 16'h0000);
    wr_reg(8'h00, monitor_pkg::SEL_ENERGY);
    disp(16'h04D2, 2'd2, 16'h04D2, 2'd2);
    wr_reg(8'h00, 16'h0017);
    disp(16'h04D2, 2'd2, 16'h0000, 2'd0);
  endtask

  task automatic s_analog();
    @(posedge clk);
    motor_running <= 1'b1;
    ao(16'h03E8, 16'h0000, 12'h333);
    ao(16'h1388, 16'h0000, 12'hFFF);
    ao(16'h1770, 16'h0000, 12'hFFF);
    wr_reg(8'h10, 16'h0BB8);
    ao(16'h03E8, 16'h0000, 12'h555);
    wr_reg(8'h10, 16'h9C41);
    rd_reg(8'h10, 16'h0BB8, "freq_ref");
    wr_reg(8'h18, 16'h0002);
    ao(16'h0000, 16'h00C8, 12'h333);
    wr_reg(8'h18, 16'h0015);
    ao(16'h0000, 16'h0000, 12'hFFF);
    wr_reg(8'h18, 16'h0001);
    wr_reg(8'h1C, 16'h0800);
    ao(16'h0BB8, 16'h0000, 12'h7FF);
    wr_reg(8'h20, 16'h0001);
    wr_reg(8'h10, 16'h1388);
    wr_reg(8'h1C, 16'h1000);
    wr_reg(8'h18, 16'h0015);
    ao(16'h0BB8, 16'h0000, 12'h999);
    rd_reg(8'h18, 16'h0001, "ao_function");
    wr_reg(8'h1C, 16'h2000);
    ao(16'h0BB8, 16'h0000, 12'hFFF);
    wr_reg(8'h20, 16'h0000);
    motor_running <= 1'b0;
  endtask

  initial
  begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    motor_running = 1'b0;
    monitor_value = 16'h0000;
    monitor_decimals = 2'd0;
    freq_monitor = 16'h0000;
    current_monitor = 16'h0000;
    nv_restore = 1'b0;
    nv_powered_hours = 16'h0000;
    nv_run_hours = 16'h0000;
    nv_powered_wraps = 16'h0000;
    nv_run_wraps = 16'h0000;
    s_hours();
    s_defaults();
    s_run();
    s_clear();
    s_wrap();
    s_energy();
    s_display();
    s_analog();
    conclude();
  end
endmodule // hour_meter_monitor_tb
`default_nettype wire
